// >>> pkg/phy_status_pkg.sv
// Constants and carrier types for the PHY status register
package phy_status_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;

	localparam logic [ADDR_W-1:0] PHY_STATUS_ADDR  = 5'h01;
	localparam logic [DATA_W-1:0] PHY_STATUS_RESET = 16'h7849;

	// Bit positions of the status word
	localparam int POS_RESERVED_TOP        = 15;
	localparam int POS_FAST_FULL_DUPLEX    = 14;
	localparam int POS_FAST_HALF_DUPLEX    = 13;
	localparam int POS_SLOW_FULL_DUPLEX    = 12;
	localparam int POS_SLOW_HALF_DUPLEX    = 11;
	localparam int POS_RESERVED_MID_HI     = 10;
	localparam int POS_RESERVED_MID_LO     = 7;
	localparam int POS_NO_PREAMBLE_OK      = 6;
	localparam int POS_NEGOTIATION_DONE    = 5;
	localparam int POS_FAR_END_FAULT       = 4;
	localparam int POS_NEGOTIATION_ABLE    = 3;
	localparam int POS_LINK_UP             = 2;
	localparam int POS_OVERLONG_TX         = 1;
	localparam int POS_EXTENDED_REGS       = 0;

	// Bits that always read as one
	localparam logic [DATA_W-1:0] FIXED_ONES_MASK =
		(16'h0001 << POS_FAST_FULL_DUPLEX) | (16'h0001 << POS_FAST_HALF_DUPLEX) |
		(16'h0001 << POS_SLOW_FULL_DUPLEX) | (16'h0001 << POS_SLOW_HALF_DUPLEX) |
		(16'h0001 << POS_NO_PREAMBLE_OK) | (16'h0001 << POS_NEGOTIATION_ABLE) |
		(16'h0001 << POS_EXTENDED_REGS);

	// Bits that always read as zero
	localparam logic [DATA_W-1:0] RESERVED_MASK =
		(16'h0001 << POS_RESERVED_TOP) |
		(16'h07ff & ~((16'h0001 << POS_RESERVED_MID_LO) - 16'h0001) &
		((16'h0001 << (POS_RESERVED_MID_HI + 1)) - 16'h0001));

	// Latched flags, one cell each
	localparam int NUM_LATCH        = 2;
	localparam int LATCH_FAR_FAULT  = 0;
	localparam int LATCH_OVERLONG   = 1;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mgmt_req_t;

	typedef struct packed {
		logic negotiation_done;
		logic link_up;
		logic far_end_fault;
		logic overlong_tx;
	} phy_cond_t;

endpackage

// >>> rtl/sticky_flag.sv
// Single latched event flag, cleared by a read, set wins over clear
`timescale 1ns/1ns
module sticky_flag (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic set_in,
	input  wire logic clear_in,
	output logic      flag
);

	typedef struct packed {
		logic flag;
	} flag_state_t;

	flag_state_t state_reg;
	flag_state_t state_next;

	always_comb begin
		state_next = state_reg;
		// An event in the clearing cycle must not be lost
		state_next.flag = set_in | (state_reg.flag & ~clear_in);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign flag = state_reg.flag;

	AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst)
		set_in |=> flag)
		else $error("flag lost an event");

	AST_CLEAR_ONLY_BY_READ: assert property (@(posedge clk) disable iff (!nrst)
		flag && !clear_in |=> flag)
		else $error("flag dropped without a clear");

endmodule

// >>> rtl/phy_status_reg.sv
// PHY status register: fixed abilities, live link state and read-cleared flags
`timescale 1ns/1ns
// How it works
// - Status word at address 0x01, resets to 0x7849
// - Bits 14..11 advertise speed/duplex abilities, one
// - Bits 15, 10..7 reserved, read as zero
// - Bit 6 one: preamble-less frames accepted
// - Bit 5 set after negotiation finishes
// - Bit 4 set on far-end fault
// - Fault flag latched until read clears it
// - Bit 3 one: negotiation ability
// - Bit 2 follows link state
// - Bit 1 set on over-long transmission
// - Over-long flag latched until read clears it
// - Bit 0 one: extended registers present
module phy_status_reg (
	input  wire logic                                   clk,
	input  wire logic                                   nrst,
	input  wire phy_status_pkg::mgmt_req_t              req,
	input  wire phy_status_pkg::phy_cond_t              cond,
	output logic [phy_status_pkg::DATA_W-1:0]           rdata
);

	typedef struct packed {
		logic [phy_status_pkg::DATA_W-1:0] rdata;
		logic                              negotiation_done;
		logic                              link_up;
	} status_state_t;

	status_state_t                          state_reg;
	status_state_t                          state_next;
	logic                                   read_hit;
	logic                                   write_hit;
	logic [phy_status_pkg::NUM_LATCH-1:0]   latch_set;
	logic [phy_status_pkg::NUM_LATCH-1:0]   latch_flag;
	logic [phy_status_pkg::DATA_W-1:0]      status_image;

	// Only a read of our own address clears; other addresses answer zero
	assign read_hit  = req.rd && (req.addr == phy_status_pkg::PHY_STATUS_ADDR);
	assign write_hit = req.wr && (req.addr == phy_status_pkg::PHY_STATUS_ADDR);

	assign latch_set[phy_status_pkg::LATCH_FAR_FAULT] = cond.far_end_fault;
	assign latch_set[phy_status_pkg::LATCH_OVERLONG]  = cond.overlong_tx;

	// Writes play no part in clearing
	genvar gi;
	generate
		for (gi = 0; gi < phy_status_pkg::NUM_LATCH; gi++) begin : g_latch
			sticky_flag u_flag (
				.clk      (clk),
				.nrst     (nrst),
				.set_in   (latch_set[gi]),
				.clear_in (read_hit),
				.flag     (latch_flag[gi])
			);
		end
	endgenerate

	always_comb begin
		status_image = phy_status_pkg::FIXED_ONES_MASK;
		status_image[phy_status_pkg::POS_NEGOTIATION_DONE] = state_reg.negotiation_done;
		status_image[phy_status_pkg::POS_FAR_END_FAULT] =
			latch_flag[phy_status_pkg::LATCH_FAR_FAULT];
		status_image[phy_status_pkg::POS_LINK_UP] = state_reg.link_up;
		status_image[phy_status_pkg::POS_OVERLONG_TX] =
			latch_flag[phy_status_pkg::LATCH_OVERLONG];
		// Reserved bits forced low whatever lands there
		status_image = status_image & ~phy_status_pkg::RESERVED_MASK;
	end

	always_comb begin
		state_next = state_reg;
		// Live conditions sampled so both read zero out of reset
		state_next.negotiation_done = cond.negotiation_done;
		state_next.link_up = cond.link_up;
		// Answer stands only in the cycle after the read
		if (read_hit) begin
			state_next.rdata = status_image;
		end else begin
			state_next.rdata = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata = state_reg.rdata;

	// Helper: marks the cycle in which a read answer stands
	logic                              read_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			read_q  <= 1'b0;
		end else begin
			read_q  <= read_hit;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence quiet_read_s;
		read_hit && !state_reg.negotiation_done && !state_reg.link_up &&
			(latch_flag == '0);
	endsequence

	AST_RESET_IMAGE: assert property (
		quiet_read_s |=> rdata == phy_status_pkg::PHY_STATUS_RESET)
		else $error("quiet read did not return reset image");

	AST_ABILITY_BITS: assert property (
		read_hit |=> rdata[14:11] == 4'hf)
		else $error("speed and duplex abilities not all one");

	AST_RESERVED_ZERO: assert property (
		(rdata & phy_status_pkg::RESERVED_MASK) == '0)
		else $error("reserved bit read as one");

	AST_NO_PREAMBLE_BIT: assert property (
		read_hit |=> rdata[phy_status_pkg::POS_NO_PREAMBLE_OK])
		else $error("preamble suppression bit low");

	AST_NEG_DONE_FOLLOWS: assert property (
		cond.negotiation_done ##1 read_hit |=>
			rdata[phy_status_pkg::POS_NEGOTIATION_DONE])
		else $error("negotiation done not reported");

	AST_NEG_DONE_LOW: assert property (
		!cond.negotiation_done ##1 read_hit |=>
			!rdata[phy_status_pkg::POS_NEGOTIATION_DONE])
		else $error("negotiation done reported early");

	AST_FAULT_SETS: assert property (
		cond.far_end_fault ##1 read_hit |=> rdata[phy_status_pkg::POS_FAR_END_FAULT])
		else $error("far end fault not reported");

	AST_FAULT_HOLDS: assert property (
		latch_flag[phy_status_pkg::LATCH_FAR_FAULT] && !read_hit
			|=> latch_flag[phy_status_pkg::LATCH_FAR_FAULT])
		else $error("fault flag fell without a read");

	AST_FAULT_READ_CLEARS: assert property (
		latch_flag[phy_status_pkg::LATCH_FAR_FAULT] && read_hit && !cond.far_end_fault
			|=> rdata[phy_status_pkg::POS_FAR_END_FAULT] &&
			!latch_flag[phy_status_pkg::LATCH_FAR_FAULT])
		else $error("fault read did not return one then clear");

	AST_NEG_ABLE_BIT: assert property (
		read_hit |=> rdata[phy_status_pkg::POS_NEGOTIATION_ABLE])
		else $error("negotiation ability bit low");

	AST_LINK_FOLLOWS: assert property (
		read_hit |=> rdata[phy_status_pkg::POS_LINK_UP] == $past(cond.link_up, 2))
		else $error("link bit does not follow link state");

	AST_JAB_SETS: assert property (
		cond.overlong_tx ##1 read_hit |=> rdata[phy_status_pkg::POS_OVERLONG_TX])
		else $error("over-long transmission not reported");

	AST_JAB_READ_CLEARS: assert property (
		latch_flag[phy_status_pkg::LATCH_OVERLONG] && read_hit && !cond.overlong_tx
			|=> rdata[phy_status_pkg::POS_OVERLONG_TX] &&
			!latch_flag[phy_status_pkg::LATCH_OVERLONG])
		else $error("over-long read did not return one then clear");

	AST_JAB_HOLDS: assert property (
		latch_flag[phy_status_pkg::LATCH_OVERLONG] && !read_hit
			|=> latch_flag[phy_status_pkg::LATCH_OVERLONG] [*1])
		else $error("over-long flag fell without a read");

	AST_EXTENDED_BIT: assert property (
		read_hit |=> rdata[phy_status_pkg::POS_EXTENDED_REGS])
		else $error("extended register bit low");

	AST_WRITE_IGNORED: assert property (
		write_hit && !read_hit && (latch_flag != '0) |=> (latch_flag & $past(latch_flag)) ==
			$past(latch_flag))
		else $error("write disturbed a latched flag");

	AST_ANSWER_ONE_CYCLE: assert property (
		!read_hit |=> rdata == '0)
		else $error("read data stood outside its cycle");

	// Built bit by bit from the state, not from the image expression
	AST_ANSWER_IS_IMAGE: assert property (
		read_q |->
			((rdata & phy_status_pkg::FIXED_ONES_MASK) == phy_status_pkg::FIXED_ONES_MASK) &&
			(rdata[phy_status_pkg::POS_NEGOTIATION_DONE] ==
				$past(state_reg.negotiation_done)) &&
			(rdata[phy_status_pkg::POS_LINK_UP] == $past(state_reg.link_up)) &&
			(rdata[phy_status_pkg::POS_FAR_END_FAULT] ==
				$past(latch_flag[phy_status_pkg::LATCH_FAR_FAULT])) &&
			(rdata[phy_status_pkg::POS_OVERLONG_TX] ==
				$past(latch_flag[phy_status_pkg::LATCH_OVERLONG])))
		else $error("answer differs from status state of the read cycle");

	COV_QUIET_READ: cover property (quiet_read_s ##1 rdata == phy_status_pkg::PHY_STATUS_RESET);
	COV_FAULT_READ: cover property (
		cond.far_end_fault ##1 !cond.far_end_fault [*3] ##1 read_hit ##1 read_hit);
	COV_JAB_RACE: cover property (
		latch_flag[phy_status_pkg::LATCH_OVERLONG] && read_hit && cond.overlong_tx);
	COV_WRITE_THEN_READ: cover property (write_hit ##1 read_hit);

endmodule

// >>> bench/mgmt_master.sv
// Management master model issuing status register reads and writes
`timescale 1ns/1ns
module mgmt_master (
	input  wire logic                              clk,
	output phy_status_pkg::mgmt_req_t              req,
	input  wire logic [phy_status_pkg::DATA_W-1:0] rdata
);

	initial req = '0;

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	// Callers may write any value, reserved bits included
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

endmodule

// >>> bench/tb.sv
// Self-checking bench for the PHY status register
`timescale 1ns/1ns
module tb;

	localparam logic [15:0] IMG = 16'h7849;

	logic                      clk;
	logic                      nrst;
	phy_status_pkg::phy_cond_t cond;
	phy_status_pkg::mgmt_req_t req;
	logic [15:0]               rdata;
	int                        error_cnt;
	int                        tests_run;

	phy_status_reg dut (
		.clk   (clk),
		.nrst  (nrst),
		.req   (req),
		.cond  (cond),
		.rdata (rdata)
	);

	mgmt_master mst (
		.clk   (clk),
		.req   (req),
		.rdata (rdata)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		mst.rd(a, d);
		chk(d, exp);
	endtask

	// One-cycle event pulses on the latched conditions
	task automatic pulse(input logic f, input logic o);
		@(posedge clk);
		cond.far_end_fault <= f;
		cond.overlong_tx   <= o;
		@(posedge clk);
		cond.far_end_fault <= 1'b0;
		cond.overlong_tx   <= 1'b0;
	endtask

	task automatic t_reset_image;
		chk(rdata, 16'h0000);
		rd_chk(5'h01, IMG);
		rd_chk(5'h02, 16'h0000);
		rd_chk(5'h00, 16'h0000);
	endtask

	task automatic t_live;
		@(posedge clk);
		cond.negotiation_done <= 1'b1;
		cond.link_up          <= 1'b1;
		rd_chk(5'h01, IMG | 16'h0024);
		@(posedge clk);
		cond.negotiation_done <= 1'b0;
		rd_chk(5'h01, IMG | 16'h0004);
		@(posedge clk);
		cond.link_up <= 1'b0;
		rd_chk(5'h01, IMG);
	endtask

	// Flag must outlive the condition, then clear on the read
	task automatic t_latch(input logic f, input logic o, input logic [15:0] m);
		pulse(f, o);
		repeat (3) @(posedge clk);
		rd_chk(5'h01, IMG | m);
		rd_chk(5'h01, IMG);
	endtask

	// Event in the clearing read: set wins, next read still shows it
	task automatic t_race;
		pulse(1'b0, 1'b1);
		fork
			rd_chk(5'h01, IMG | 16'h0002);
			begin
				@(posedge clk);
				cond.overlong_tx <= 1'b1;
				@(posedge clk);
				cond.overlong_tx <= 1'b0;
			end
		join
		rd_chk(5'h01, IMG | 16'h0002);
		rd_chk(5'h01, IMG);
	endtask

	task automatic t_write;
		pulse(1'b1, 1'b1);
		mst.wr(5'h01, 16'hffff);
		mst.wr(5'h01, 16'h0000);
		rd_chk(5'h01, IMG | 16'h0012);
		rd_chk(5'h01, IMG);
	endtask

	initial begin
		nrst      = 1'b0;
		cond      = '0;
		error_cnt = 0;
		tests_run = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		t_reset_image();
		t_live();
		t_latch(1'b1, 1'b0, 16'h0010);
		t_latch(1'b0, 1'b1, 16'h0002);
		t_write();
		t_race();
		end_sim();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("MISMATCH t=%0t run did not finish", $time);
		end_sim();
	end

endmodule
